// ### bench/ismask_chk.sv
// Checker for the interrupt source mask block ports.
// Assumes it is bound onto ismask_top and shares its clock and reset.
`timescale 1ns/1ps
`include "ismask_defs.svh"

module ismask_chk (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Events and interrupt
  input wire logic ref_input_one_in,
  input wire logic ref_input_two_in,
  input wire logic ref_input_three_in,
  input wire logic ref_input_four_in,
  input wire logic mode_change_in,
  input wire logic main_ref_fail_in,
  input wire logic secondary_loop_state_in,
  input wire logic irq_out
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire acc = psel_in && penable_in;
  wire wr = acc && pwrite_in;
  wire rd = acc && !pwrite_in;
  wire ev = ref_input_one_in | ref_input_two_in | ref_input_three_in | ref_input_four_in |
    mode_change_in | main_ref_fail_in | secondary_loop_state_in;
  wire lo = paddr_in == `ISM_ADDR_EN_LOW;
  wire mi = paddr_in == `ISM_ADDR_EN_MID;
  wire hi = paddr_in == `ISM_ADDR_EN_HIGH;
  wire st = paddr_in == `ISM_ADDR_STATUS;
  wire cl = paddr_in == `ISM_ADDR_CLEAR;
  wire bad = !(lo || mi || hi || st || cl) || (pwrite_in && st) || (!pwrite_in && cl);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_ready; psel_in && !penable_in |=> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_idle; !acc |-> !pready_out; endproperty
  a_idle: assert property (p_idle) else $error("ready outside access");
  property p_err; acc |-> pslverr_out == bad; endproperty
  a_err: assert property (p_err) else $error("wrong error response");
  property p_low; rd && lo |-> (prdata_out & ~{24'h0, `ISM_LOW_USED}) == 32'h0; endproperty
  a_low: assert property (p_low) else $error("low byte unused bits set");
  property p_mid; rd && mi |-> (prdata_out & ~{24'h0, `ISM_MID_USED}) == 32'h0; endproperty
  a_mid: assert property (p_mid) else $error("mid byte unused bits set");
  property p_high; rd && hi |-> (prdata_out & ~{24'h0, `ISM_HIGH_USED}) == 32'h0; endproperty
  a_high: assert property (p_high) else $error("high byte unused bits set");
  // Irq moves only after a register write or a recent event
  property p_rise; $rose(irq_out) |-> $past(wr, 2) || $past(ev, 4) || $past(ev, 5); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without cause");
  property p_fall; $fell(irq_out) |-> $past(wr, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq fell without write");
endmodule

bind ismask_top ismask_chk u_chk (.clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .prdata_out, .pready_out, .pslverr_out, .ref_input_one_in, .ref_input_two_in,
  .ref_input_three_in, .ref_input_four_in, .mode_change_in, .main_ref_fail_in,
  .secondary_loop_state_in, .irq_out);

// ### bench/tb_top.sv
// Bench for the interrupt source mask: APB master, event pins, verdict.
// Assumes design and checker files are compiled before it.
`timescale 1ns/1ps
`include "ismask_defs.svh"

module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [6:0] ev = 7'h0;
  logic [31:0] prdata_out, rd;
  logic pready_out, pslverr_out, irq_out, er;
  int err_total = 0;
  int n_compared = 0;
  // Enable register and bit per source, in status bit order
  logic [11:0] en_addr [7] = '{`ISM_ADDR_EN_LOW, `ISM_ADDR_EN_LOW, `ISM_ADDR_EN_LOW,
    `ISM_ADDR_EN_MID, `ISM_ADDR_EN_MID, `ISM_ADDR_EN_MID, `ISM_ADDR_EN_HIGH};
  int en_bit [7] = '{2, 3, 7, 0, 7, 6, 6};
  initial forever #25 clock_in = ~clock_in;
  ismask_top uut (.clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .ref_input_one_in(ev[0]),
    .ref_input_two_in(ev[1]), .ref_input_three_in(ev[2]), .ref_input_four_in(ev[3]),
    .mode_change_in(ev[4]), .main_ref_fail_in(ev[5]), .secondary_loop_state_in(ev[6]),
    .irq_out);
  task automatic test_done;
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request holds until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do @(posedge clock_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Level held long enough to pass the synchroniser, then low to re-arm
  task automatic pulse(input int i);
    @(posedge clock_in);
    ev[i] <= 1'b1;
    repeat (6) @(posedge clock_in);
    ev[i] <= 1'b0;
    repeat (3) @(negedge clock_in);
  endtask
  task automatic wr_wait(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(negedge clock_in);
  endtask
  task automatic t_reset;
    rdchk(`ISM_ADDR_EN_LOW, 32'h0);
    rdchk(`ISM_ADDR_EN_MID, 32'h0);
    rdchk(`ISM_ADDR_EN_HIGH, 32'h0);
  endtask
  task automatic t_rw;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `ISM_ADDR_EN_LOW + 12'h4 * i, 32'hffffffff);
    end
    rdchk(`ISM_ADDR_EN_LOW, 32'h8c);
    rdchk(`ISM_ADDR_EN_MID, 32'hc1);
    rdchk(`ISM_ADDR_EN_HIGH, 32'h40);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `ISM_ADDR_EN_LOW + 12'h4 * i, 32'h0);
    end
    rdchk(`ISM_ADDR_EN_MID, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task automatic t_src;
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      chk({31'h0, irq_out}, 32'h0);
      rdchk(`ISM_ADDR_STATUS, 32'h1 << i);
      wr_wait(en_addr[i], 32'h1 << en_bit[i]);
      chk({31'h0, irq_out}, 32'h1);
      wr_wait(`ISM_ADDR_CLEAR, 32'h1 << i);
      chk({31'h0, irq_out}, 32'h0);
      pulse(i);
      chk({31'h0, irq_out}, 32'h1);
      wr_wait(en_addr[i], 32'h0);
      chk({31'h0, irq_out}, 32'h0);
      apb(1'b1, `ISM_ADDR_CLEAR, 32'h1 << i);
    end
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset;
    t_rw;
    t_src;
    test_done;
  end
  // Run needs about 300 cycles; the margin is generous
  initial begin
    repeat (5000) @(posedge clock_in);
    err_total++;
    test_done;
  end
endmodule

// ### hw/ismask_defs.svh
// Constants for the interrupt source mask block: offsets, fields, resets.
// Assumes inclusion by bare name from the package and design files.
`ifndef ISMASK_DEFS_SVH
`define ISMASK_DEFS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define ISM_IDX_EN_LOW 8'h43
`define ISM_IDX_EN_MID 8'h44
`define ISM_IDX_EN_HIGH 8'h45
`define ISM_IDX_STATUS 8'h50
`define ISM_IDX_CLEAR 8'h51
`define ISM_ADDR_EN_LOW 12'h10c
`define ISM_ADDR_EN_MID 12'h110
`define ISM_ADDR_EN_HIGH 12'h114
`define ISM_ADDR_STATUS 12'h140
`define ISM_ADDR_CLEAR 12'h144

// ----------------------------------------
// Mask bit positions
// ----------------------------------------
`define ISM_LOW_REF3 7
`define ISM_LOW_REF2 3
`define ISM_LOW_REF1 2
`define ISM_MID_REF4 0
`define ISM_MID_MODE 7
`define ISM_MID_FAIL 6
`define ISM_HIGH_SEC 6

// ----------------------------------------
// Used bits and reset values
// ----------------------------------------
`define ISM_LOW_USED 8'h8c
`define ISM_MID_USED 8'hc1
`define ISM_HIGH_USED 8'h40
`define ISM_MASK_RESET 8'h00
`define ISM_STATUS_RESET 8'h00
`define ISM_NUM_SRC 7

`endif

// ### hw/ismask_pkg.sv
// Types for the interrupt source mask block.
// Assumes ismask_defs.svh is on the include path.
`include "ismask_defs.svh"

package ismask_pkg;
  // Event source order within the status and enable vectors
  typedef enum logic [2:0] {
    ISM_SRC_REF1 = 3'h0,
    ISM_SRC_REF2 = 3'h1,
    ISM_SRC_REF3 = 3'h2,
    ISM_SRC_REF4 = 3'h3,
    ISM_SRC_MODE = 3'h4,
    ISM_SRC_FAIL = 3'h5,
    ISM_SRC_SEC = 3'h6
  } ismask_src_t;
  typedef logic [`ISM_NUM_SRC-1:0] ismask_vec_t;
endpackage

// ### hw/ismask_reg8.sv
// One 8-bit mask register with a write strobe and a used-bit mask.
// Assumes a strobe from the bus slave on the same clock.
`timescale 1ns/1ps
`include "ismask_defs.svh"

module ismask_reg8 #(
  parameter logic [7:0] USED = 8'hff
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Write side
  input wire logic wr_in,
  input wire logic [7:0] data_in,
  // Stored value
  output logic [7:0] value_out
);
  // Unused positions never store, so they read zero and cannot gate
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      value_out <= `ISM_MASK_RESET;
    end else if (wr_in) begin
      value_out <= data_in & USED;
    end
  end
endmodule

// ### hw/ismask_top.sv
// Interrupt source mask: three enable bytes, sticky status, one irq line.
// Assumes event inputs are single-cycle pulses or levels from other
// clock domains; each passes a two-flop synchroniser first.
`timescale 1ns/1ps
`include "ismask_defs.svh"

module ismask_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Event sources, asynchronous levels
  input wire logic ref_input_one_in,
  input wire logic ref_input_two_in,
  input wire logic ref_input_three_in,
  input wire logic ref_input_four_in,
  input wire logic mode_change_in,
  input wire logic main_ref_fail_in,
  input wire logic secondary_loop_state_in,
  // Interrupt
  output logic irq_out
);
  import ismask_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Exact word match; no partial decode, so aliases read as unmapped
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] target);
    addr_hit = (addr == target);
  endfunction

  // Zero-extend a mask byte to the bus width
  function automatic logic [31:0] widen8(input logic [7:0] value);
    widen8 = {24'h000000, value};
  endfunction

  // A source interrupts only while pending and enabled
  function automatic logic gate(input logic stat, input logic en);
    gate = stat & en;
  endfunction

  // ----------------------------------------
  // Event synchronisers and edge detect
  // ----------------------------------------
  ismask_vec_t raw_ev;
  ismask_vec_t sync_a;
  ismask_vec_t sync_b;
  ismask_vec_t sync_c;
  ismask_vec_t ev_pulse;

  assign raw_ev[ISM_SRC_REF1] = ref_input_one_in;
  assign raw_ev[ISM_SRC_REF2] = ref_input_two_in;
  assign raw_ev[ISM_SRC_REF3] = ref_input_three_in;
  assign raw_ev[ISM_SRC_REF4] = ref_input_four_in;
  assign raw_ev[ISM_SRC_MODE] = mode_change_in;
  assign raw_ev[ISM_SRC_FAIL] = main_ref_fail_in;
  assign raw_ev[ISM_SRC_SEC] = secondary_loop_state_in;

  // Rising edge only; a held level counts once
  assign ev_pulse = sync_b & ~sync_c;

  // First stage may go metastable; only the second stage reads it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync_a <= '0;
    end else begin
      sync_a <= raw_ev;
    end
  end

  // Second stage, the first one logic may read
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync_b <= '0;
    end else begin
      sync_b <= sync_a;
    end
  end

  // Delayed copy for the edge detector; resets to the idle pin level
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync_c <= '0;
    end else begin
      sync_c <= sync_b;
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic access = psel_in & penable_in;
  wire logic wr = access & pwrite_in;
  wire logic hit_low = addr_hit(paddr_in, `ISM_ADDR_EN_LOW);
  wire logic hit_mid = addr_hit(paddr_in, `ISM_ADDR_EN_MID);
  wire logic hit_high = addr_hit(paddr_in, `ISM_ADDR_EN_HIGH);
  wire logic hit_stat = addr_hit(paddr_in, `ISM_ADDR_STATUS);
  wire logic hit_clr = addr_hit(paddr_in, `ISM_ADDR_CLEAR);
  wire logic mapped = hit_low | hit_mid | hit_high | hit_stat | hit_clr;
  // Status is read-only, clear is write-only
  wire logic wr_to_status = hit_stat & pwrite_in;
  wire logic rd_of_clear = hit_clr & ~pwrite_in;
  wire logic bad = ~mapped | wr_to_status | rd_of_clear;

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  // Refused writes still reach no register, since each strobe needs a hit
  wire logic wr_low = wr & hit_low;
  wire logic wr_mid = wr & hit_mid;
  wire logic wr_high = wr & hit_high;
  wire logic wr_clr = wr & hit_clr;

  // ----------------------------------------
  // Mask registers
  // ----------------------------------------
  logic [7:0] irq_enable_low;
  logic [7:0] irq_enable_mid;
  logic [7:0] irq_enable_high;

  ismask_reg8 #(.USED(`ISM_LOW_USED)) u_low (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_in(wr_low),
    .data_in(pwdata_in[7:0]),
    .value_out(irq_enable_low)
  );

  ismask_reg8 #(.USED(`ISM_MID_USED)) u_mid (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_in(wr_mid),
    .data_in(pwdata_in[7:0]),
    .value_out(irq_enable_mid)
  );

  ismask_reg8 #(.USED(`ISM_HIGH_USED)) u_high (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_in(wr_high),
    .data_in(pwdata_in[7:0]),
    .value_out(irq_enable_high)
  );

  // ----------------------------------------
  // Enable vector in source order
  // ----------------------------------------
  ismask_vec_t enable;
  assign enable[ISM_SRC_REF3] = irq_enable_low[`ISM_LOW_REF3];
  assign enable[ISM_SRC_REF2] = irq_enable_low[`ISM_LOW_REF2];
  assign enable[ISM_SRC_REF1] = irq_enable_low[`ISM_LOW_REF1];
  assign enable[ISM_SRC_REF4] = irq_enable_mid[`ISM_MID_REF4];
  assign enable[ISM_SRC_MODE] = irq_enable_mid[`ISM_MID_MODE];
  assign enable[ISM_SRC_FAIL] = irq_enable_mid[`ISM_MID_FAIL];
  assign enable[ISM_SRC_SEC] = irq_enable_high[`ISM_HIGH_SEC];

  // ----------------------------------------
  // Sticky status, write one to clear
  // ----------------------------------------
  ismask_vec_t status;
  ismask_vec_t clr_bits;
  ismask_vec_t next_status;
  assign clr_bits = wr_clr ? pwdata_in[`ISM_NUM_SRC-1:0] : '0;
  // New event wins over a clear in the same cycle
  assign next_status = (status & ~clr_bits) | ev_pulse;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // ----------------------------------------
  // Per-source gating
  // ----------------------------------------
  // Reference input one, low byte
  wire logic stat_ref1 = status[ISM_SRC_REF1];
  wire logic pend_ref1 = gate(stat_ref1, enable[ISM_SRC_REF1]);

  // Reference input two, low byte
  wire logic stat_ref2 = status[ISM_SRC_REF2];
  wire logic pend_ref2 = gate(stat_ref2, enable[ISM_SRC_REF2]);

  // Reference input three, low byte
  wire logic stat_ref3 = status[ISM_SRC_REF3];
  wire logic pend_ref3 = gate(stat_ref3, enable[ISM_SRC_REF3]);

  // Reference input four, middle byte
  wire logic stat_ref4 = status[ISM_SRC_REF4];
  wire logic pend_ref4 = gate(stat_ref4, enable[ISM_SRC_REF4]);

  // Main loop mode change, middle byte
  wire logic stat_mode = status[ISM_SRC_MODE];
  wire logic pend_mode = gate(stat_mode, enable[ISM_SRC_MODE]);

  // Main reference failure, middle byte
  wire logic stat_fail = status[ISM_SRC_FAIL];
  wire logic pend_fail = gate(stat_fail, enable[ISM_SRC_FAIL]);

  // Secondary loop status change, high byte
  wire logic stat_sec = status[ISM_SRC_SEC];
  wire logic pend_sec = gate(stat_sec, enable[ISM_SRC_SEC]);

  ismask_vec_t pending;
  assign pending[ISM_SRC_REF1] = pend_ref1;
  assign pending[ISM_SRC_REF2] = pend_ref2;
  assign pending[ISM_SRC_REF3] = pend_ref3;
  assign pending[ISM_SRC_REF4] = pend_ref4;
  assign pending[ISM_SRC_MODE] = pend_mode;
  assign pending[ISM_SRC_FAIL] = pend_fail;
  assign pending[ISM_SRC_SEC] = pend_sec;

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // Irq is registered, so it trails status by one cycle
  wire logic next_irq = |pending;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= next_irq;
    end
  end

  // ----------------------------------------
  // Read data and answer
  // ----------------------------------------
  wire logic setup = psel_in & ~penable_in;
  wire logic rd_low = hit_low & ~pwrite_in;
  wire logic rd_mid = hit_mid & ~pwrite_in;
  wire logic rd_high = hit_high & ~pwrite_in;
  wire logic rd_stat = hit_stat & ~pwrite_in;

  logic [31:0] next_rdata;
  assign next_rdata = rd_low ? widen8(irq_enable_low) :
                      rd_mid ? widen8(irq_enable_mid) :
                      rd_high ? widen8(irq_enable_high) :
                      rd_stat ? {25'h0000000, status} :
                      32'h00000000;

  // Read data is caught in setup and held, so it stands through access
  wire logic [31:0] held_rdata = setup ? next_rdata : prdata_out;
  // Zero-wait answer: ready is high in every access phase
  wire logic next_ready = setup;
  wire logic next_err = setup & bad;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= 32'h00000000;
    end else begin
      prdata_out <= held_rdata;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= next_ready;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= next_err;
    end
  end
endmodule
